// file: core/video_capture_consts.vh
// Purpose: Shared constants for the video input capture block.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Times are kept in their own unit; cycle counts derive from the clock period.
`ifndef VIDEO_CAPTURE_CONSTS_VH
`define VIDEO_CAPTURE_CONSTS_VH

// System clock period in ns (50 MHz)
`define VC_SYS_CLK_NS        20

// Least reset pulse the outside world must give, in ns and in cycles (rounded up)
`define VC_RESET_MIN_NS      100
`define VC_RESET_MIN_CYCLES  ((`VC_RESET_MIN_NS + `VC_SYS_CLK_NS - 1) / `VC_SYS_CLK_NS)

// Least host serial clock high time during reset, in ns and in cycles (rounded up)
`define VC_SCLK_HIGH_NS      50
`define VC_SCLK_HIGH_CYCLES  ((`VC_SCLK_HIGH_NS + `VC_SYS_CLK_NS - 1) / `VC_SYS_CLK_NS)

// Rising edges each selected clock must deliver before operation starts
`define VC_START_EDGES       4'h8
`define VC_EDGE_CNT_W        4

// Default counter widths
`define VC_LINE_W            11
`define VC_PIX_W             12

// Colour and pixel widths
`define VC_COLOUR_W          8
`define VC_RGB_W             24
`define VC_PAIR_W            48

// Control reset values: every programmable control bit clears to zero
`define VC_CTL_RESET         1'b0

// Clock select encodings
`define VC_SEL_PRIMARY       1'b0
`define VC_SEL_SECONDARY     1'b1
`define VC_SEL_DISP_ONE      1'b0
`define VC_SEL_DISP_TWO      1'b1

`endif

// file: core/pin_sync.v
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to clk_sys; the group is resampled bit by bit.
// Notes:   Only the second flop feeds downstream logic.
`timescale 1ns/100ps

module pin_sync #(
	parameter WIDTH = 1
) (
	// Clock, reset and enable
	input  wire             clk_sys,
	input  wire             nrst,
	input  wire             clk_en,
	// Asynchronous in, synchronised out
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta;

	// First stage is read by the second stage only
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule // pin_sync

// file: core/video_input_capture.v
// Purpose: Input port front end of a video scaler: primary and secondary pixel ports.
// Assumes: All pixel-side pins are asynchronous and oversampled by clk_sys.
// Notes:   Pixel clocks must stay well below half of clk_sys for edges to be seen.
//
// Summary of operation
// - Reset clears all programmable control to zero
// - Wait eight edges on both selected clocks
// - Reset selects primary clock, display clock one
// - Secondary port has own clock, selectable edge
// - Secondary samples only on qualified edges
// - Primary samples only on qualified edges
// - Primary sampling edge is programmable
// - Double pixel: left secondary, right primary
// - Active samples per line always even
// - Vertical sync on qualified cycle starts field
// - Sync active levels are programmable
// - Horizontal sync prepares next line
// - Each line waits for its horizontal sync
// - Odd indicator picks odd or even start
// - Progressive sources treat every field odd
// - Odd indicator polarity programmable, high default
`timescale 1ns/100ps
`include "video_capture_consts.vh"

module video_input_capture #(
	parameter LINE_W = `VC_LINE_W,
	parameter PIX_W  = `VC_PIX_W
) (
	// System clock, reset and enable
	input  wire                     clk_sys,
	input  wire                     nrst,
	input  wire                     clk_en,
	// Primary port pins
	input  wire                     primary_pixel_clock,
	input  wire                     primary_clock_qualifier,
	input  wire                     primary_vertical_sync,
	input  wire                     primary_horizontal_sync,
	input  wire [`VC_COLOUR_W-1:0]  primary_red_bus,
	input  wire [`VC_COLOUR_W-1:0]  primary_green_bus,
	input  wire [`VC_COLOUR_W-1:0]  primary_blue_bus,
	input  wire [`VC_COLOUR_W-1:0]  primary_luma_bus,
	input  wire [`VC_COLOUR_W-1:0]  primary_chroma_bus,
	input  wire                     odd_field_indicator,
	// Secondary port pins
	input  wire                     secondary_pixel_clock,
	input  wire                     secondary_clock_qualifier,
	input  wire                     secondary_vertical_sync,
	input  wire                     secondary_horizontal_sync,
	input  wire [`VC_COLOUR_W-1:0]  secondary_red_bus,
	input  wire [`VC_COLOUR_W-1:0]  secondary_green_bus,
	input  wire [`VC_COLOUR_W-1:0]  secondary_blue_bus,
	// Display reference clocks
	input  wire                     display_ref_clock_one,
	input  wire                     display_ref_clock_two,
	// Host control settings, taken while control_load is high
	input  wire                     control_load,
	input  wire                     input_clock_select,
	input  wire                     display_clock_select,
	input  wire                     primary_falling_edge,
	input  wire                     secondary_falling_edge,
	input  wire                     vsync_active_low,
	input  wire                     hsync_active_low,
	input  wire                     odd_active_low,
	input  wire                     interlaced,
	input  wire                     double_pixel,
	input  wire                     yuv_mode,
	input  wire [LINE_W-1:0]        odd_field_vertical_start,
	input  wire [LINE_W-1:0]        even_field_vertical_start,
	input  wire [PIX_W-1:0]         active_h_start,
	input  wire [PIX_W-1:0]         active_width,
	// Status and captured stream
	output reg                      capture_ready,
	output reg                      field_start,
	output reg                      line_start,
	output reg                      field_odd,
	output reg                      line_active,
	output reg  [LINE_W-1:0]        line_number,
	output reg                      pixel_valid,
	output reg                      pixel_pair,
	output reg  [`VC_PAIR_W-1:0]    pixel_data
);

	localparam P_W = 5 + 5 * `VC_COLOUR_W;
	localparam S_W = 4 + 3 * `VC_COLOUR_W;

	// Held control settings
	reg              ctl_input_sel;
	reg              ctl_disp_sel;
	reg              ctl_p_fall;
	reg              ctl_s_fall;
	reg              ctl_vs_low;
	reg              ctl_hs_low;
	reg              ctl_odd_low;
	reg              ctl_interlaced;
	reg              ctl_double;
	reg              ctl_yuv;
	reg [LINE_W-1:0] ctl_odd_start;
	reg [LINE_W-1:0] ctl_even_start;
	reg [PIX_W-1:0]  ctl_h_start;
	reg [PIX_W-1:0]  ctl_width;

	// Synchronised pin groups
	wire [P_W-1:0]   p_sync;
	wire [S_W-1:0]   s_sync;
	wire [1:0]       d_sync;

	// Previous clock levels for edge finding
	reg              p_clk_prev;
	reg              s_clk_prev;
	reg              d1_prev;
	reg              d2_prev;

	// Start-up edge counters, and a settle count while the edge history fills with real pin levels
	reg [1:0]                settle;
	reg [`VC_EDGE_CNT_W-1:0] in_edges;
	reg [`VC_EDGE_CNT_W-1:0] disp_edges;

	// Sync history and line state
	reg              vs_prev;
	reg              hs_prev;
	reg              line_open;
	reg [PIX_W-1:0]  pixel_count;

	// Primary group: clock, qualifier, syncs, odd, red, green, blue, luma, chroma
	pin_sync #(.WIDTH(P_W)) u_sync_primary (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.async_in ({primary_pixel_clock, primary_clock_qualifier, primary_vertical_sync,
		            primary_horizontal_sync, odd_field_indicator, primary_red_bus,
		            primary_green_bus, primary_blue_bus, primary_luma_bus, primary_chroma_bus}),
		.sync_out (p_sync)
	);

	// Secondary group: clock, qualifier, syncs, red, green, blue
	pin_sync #(.WIDTH(S_W)) u_sync_secondary (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.async_in ({secondary_pixel_clock, secondary_clock_qualifier, secondary_vertical_sync,
		            secondary_horizontal_sync, secondary_red_bus, secondary_green_bus,
		            secondary_blue_bus}),
		.sync_out (s_sync)
	);

	// Display reference clocks
	pin_sync #(.WIDTH(2)) u_sync_display (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.async_in ({display_ref_clock_two, display_ref_clock_one}),
		.sync_out (d_sync)
	);

	// Unpack synchronised primary pins
	wire                    p_clk   = p_sync[P_W-1];
	wire                    p_qual  = p_sync[P_W-2];
	wire                    p_vs    = p_sync[P_W-3];
	wire                    p_hs    = p_sync[P_W-4];
	wire                    p_odd   = p_sync[P_W-5];
	wire [`VC_RGB_W-1:0]    p_rgb   = p_sync[P_W-6 -: `VC_RGB_W];
	wire [`VC_COLOUR_W-1:0] p_luma  = p_sync[2*`VC_COLOUR_W-1 -: `VC_COLOUR_W];
	wire [`VC_COLOUR_W-1:0] p_chrom = p_sync[`VC_COLOUR_W-1:0];

	// Unpack synchronised secondary pins
	wire                    s_clk   = s_sync[S_W-1];
	wire                    s_qual  = s_sync[S_W-2];
	wire                    s_vs    = s_sync[S_W-3];
	wire                    s_hs    = s_sync[S_W-4];
	wire [`VC_RGB_W-1:0]    s_rgb   = s_sync[`VC_RGB_W-1:0];

	// Edge finding on the synchronised clocks
	wire p_rise = p_clk & ~p_clk_prev;
	wire p_fall = ~p_clk & p_clk_prev;
	wire s_rise = s_clk & ~s_clk_prev;
	wire s_fall = ~s_clk & s_clk_prev;
	wire d1_rise = d_sync[0] & ~d1_prev;
	wire d2_rise = d_sync[1] & ~d2_prev;

	// Programmed sampling edge of each port
	wire p_edge = ctl_p_fall ? p_fall : p_rise;
	wire s_edge = ctl_s_fall ? s_fall : s_rise;

	// Double pixel mode runs both halves from the secondary clock and controls
	wire use_secondary = (ctl_input_sel == `VC_SEL_SECONDARY) | ctl_double;

	// A sample is taken only on a qualified selected edge
	wire qualified = capture_ready & (use_secondary ? (s_edge & s_qual)
	                                                : (p_edge & p_qual));

	// Start-up edges from the selected input and display clocks; the flops clear low in reset,
	// so a clock already high at release would look like a rising edge until they have settled
	wire primed    = (settle == 2'h3);
	wire in_rise   = primed & (use_secondary ? s_rise : p_rise);
	wire disp_rise = primed & ((ctl_disp_sel == `VC_SEL_DISP_TWO) ? d2_rise : d1_rise);

	// Sync and odd levels folded to active-high
	wire vs_level  = (use_secondary ? s_vs : p_vs) ^ ctl_vs_low;
	wire hs_level  = (use_secondary ? s_hs : p_hs) ^ ctl_hs_low;
	wire odd_level = p_odd ^ ctl_odd_low;

	// Transition from inactive to active between qualified samples
	wire vs_start = qualified & vs_level & ~vs_prev;
	wire hs_start = qualified & hs_level & ~hs_prev;

	// Field parity and the vertical start it selects
	wire parity_odd = ~ctl_interlaced | odd_level;
	wire [LINE_W-1:0] v_start = parity_odd ? ctl_odd_start : ctl_even_start;
	wire [LINE_W-1:0] next_line = line_number + {{(LINE_W-1){1'b0}}, 1'b1};

	// Horizontal window with the width forced even
	wire [PIX_W-1:0] width_even = {ctl_width[PIX_W-1:1], 1'b0};
	wire [PIX_W:0]   h_end      = {1'b0, ctl_h_start} + {1'b0, width_even};
	wire [PIX_W:0]   pix_ext    = {1'b0, pixel_count};
	wire             in_hwin    = (pix_ext >= {1'b0, ctl_h_start}) & (pix_ext < h_end);
	wire             last_pixel = (pix_ext + {{PIX_W{1'b0}}, 1'b1}) >= h_end;
	wire             take_pixel = qualified & line_open & line_active & ~hs_start & ~vs_start & in_hwin;

	// Control settings, cleared by reset so that primary and display one are selected
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctl_input_sel  <= `VC_SEL_PRIMARY;
			ctl_disp_sel   <= `VC_SEL_DISP_ONE;
			ctl_p_fall     <= `VC_CTL_RESET;
			ctl_s_fall     <= `VC_CTL_RESET;
			ctl_vs_low     <= `VC_CTL_RESET;
			ctl_hs_low     <= `VC_CTL_RESET;
			ctl_odd_low    <= `VC_CTL_RESET;
			ctl_interlaced <= `VC_CTL_RESET;
			ctl_double     <= `VC_CTL_RESET;
			ctl_yuv        <= `VC_CTL_RESET;
			ctl_odd_start  <= {LINE_W{1'b0}};
			ctl_even_start <= {LINE_W{1'b0}};
			ctl_h_start    <= {PIX_W{1'b0}};
			ctl_width      <= {PIX_W{1'b0}};
		end else if (clk_en && control_load) begin
			ctl_input_sel  <= input_clock_select;
			ctl_disp_sel   <= display_clock_select;
			ctl_p_fall     <= primary_falling_edge;
			ctl_s_fall     <= secondary_falling_edge;
			ctl_vs_low     <= vsync_active_low;
			ctl_hs_low     <= hsync_active_low;
			ctl_odd_low    <= odd_active_low;
			ctl_interlaced <= interlaced;
			ctl_double     <= double_pixel;
			ctl_yuv        <= yuv_mode;
			ctl_odd_start  <= odd_field_vertical_start;
			ctl_even_start <= even_field_vertical_start;
			ctl_h_start    <= active_h_start;
			ctl_width      <= active_width;
		end
	end

	// Clock level history for edge finding
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			p_clk_prev <= 1'b0;
			s_clk_prev <= 1'b0;
			d1_prev    <= 1'b0;
			d2_prev    <= 1'b0;
		end else if (clk_en) begin
			p_clk_prev <= p_clk;
			s_clk_prev <= s_clk;
			d1_prev    <= d_sync[0];
			d2_prev    <= d_sync[1];
		end
	end

	// Start-up: both selected clocks must show eight rising edges
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			settle        <= 2'h0;
			in_edges      <= {`VC_EDGE_CNT_W{1'b0}};
			disp_edges    <= {`VC_EDGE_CNT_W{1'b0}};
			capture_ready <= 1'b0;
		end else if (clk_en) begin
			if (settle != 2'h3)
				settle <= settle + 2'h1;
			if (in_rise && in_edges != `VC_START_EDGES)
				in_edges <= in_edges + {{(`VC_EDGE_CNT_W-1){1'b0}}, 1'b1};
			if (disp_rise && disp_edges != `VC_START_EDGES)
				disp_edges <= disp_edges + {{(`VC_EDGE_CNT_W-1){1'b0}}, 1'b1};
			if (in_edges == `VC_START_EDGES && disp_edges == `VC_START_EDGES)
				capture_ready <= 1'b1;
		end
	end

	// Sync history, updated on qualified samples only
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			vs_prev <= 1'b0;
			hs_prev <= 1'b0;
		end else if (clk_en && qualified) begin
			vs_prev <= vs_level;
			hs_prev <= hs_level;
		end
	end

	// Field and line tracking
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			field_start <= 1'b0;
			line_start  <= 1'b0;
			field_odd   <= 1'b0;
			line_active <= 1'b0;
			line_number <= {LINE_W{1'b0}};
		end else if (clk_en) begin
			field_start <= vs_start;
			line_start  <= hs_start & ~vs_start;
			if (vs_start) begin
				line_number <= {LINE_W{1'b0}};
				line_active <= 1'b0;
			end else if (hs_start) begin
				line_number <= next_line;
				if (next_line == v_start) begin
					line_active <= 1'b1;
					field_odd   <= parity_odd;
				end
			end
		end
	end

	// Per-line pixel counting; the line closes after the window and waits for sync
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			line_open   <= 1'b0;
			pixel_count <= {PIX_W{1'b0}};
		end else if (clk_en) begin
			if (vs_start) begin
				line_open <= 1'b0;
			end else if (hs_start) begin
				line_open   <= 1'b1;
				pixel_count <= {PIX_W{1'b0}};
			end else if (qualified && line_open) begin
				pixel_count <= pixel_count + {{(PIX_W-1){1'b0}}, 1'b1};
				if (in_hwin && last_pixel)
					line_open <= 1'b0;
			end
		end
	end

	// Captured pixel stream
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pixel_valid <= 1'b0;
			pixel_pair  <= 1'b0;
			pixel_data  <= {`VC_PAIR_W{1'b0}};
		end else if (clk_en) begin
			pixel_valid <= take_pixel;
			if (take_pixel) begin
				pixel_pair <= ctl_double;
				if (ctl_double)
					pixel_data <= {s_rgb, p_rgb};
				else if (use_secondary)
					pixel_data <= {{`VC_RGB_W{1'b0}}, s_rgb};
				else if (ctl_yuv)
					pixel_data <= {{`VC_RGB_W{1'b0}}, p_luma, p_chrom, {`VC_COLOUR_W{1'b0}}};
				else
					pixel_data <= {{`VC_RGB_W{1'b0}}, p_rgb};
			end
		end
	end

endmodule // video_input_capture

// file: verif/video_capture_monitor.sv
// Purpose: Port checks for the video input capture block
// Assumes: Bound to video_input_capture; syncs and clocks oversampled by clk_sys
// Notes:   Start-up edges are counted on raw pin samples, ahead of the design
`timescale 1ns/100ps

module video_capture_monitor #(
	parameter LINE_W = 11
) (
	// Clock and reset
	input wire logic              clk_sys,
	input wire logic              nrst,
	// Clocks counted at start-up
	input wire logic              primary_pixel_clock,
	input wire logic              display_ref_clock_one,
	// Watched outputs
	input wire logic              capture_ready,
	input wire logic              field_start,
	input wire logic              line_start,
	input wire logic              field_odd,
	input wire logic              line_active,
	input wire logic [LINE_W-1:0] line_number,
	input wire logic              pixel_valid
);
	logic [1:0] prev;
	logic [3:0] n_pix;
	logic [3:0] n_disp;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// Saturating counts of rising edges; prev starts high so reset gives no false edge
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prev   <= 2'h3;
			n_pix  <= 4'h0;
			n_disp <= 4'h0;
		end else begin
			prev <= {primary_pixel_clock, display_ref_clock_one};
			if (primary_pixel_clock && !prev[1] && n_pix != 4'hF)
				n_pix <= n_pix + 4'h1;
			if (display_ref_clock_one && !prev[0] && n_disp != 4'hF)
				n_disp <= n_disp + 4'h1;
		end
	end

	a_ready_edges: assert property ($rose(capture_ready) |-> n_pix >= 4'h8 && n_disp >= 4'h8)
		else $error("capture ready before eight clock edges");
	a_ready_holds: assert property (capture_ready |=> capture_ready)
		else $error("capture ready dropped without reset");
	a_quiet_unready: assert property (!capture_ready |-> !field_start && !line_start && !pixel_valid)
		else $error("activity before capture ready");
	a_field_restart: assert property (field_start |=> !field_start && !line_active && line_number == 0)
		else $error("field start did not restart the field");
	a_line_count: assert property (line_start |-> line_number == $past(line_number) + 1'b1)
		else $error("line start did not advance line number");
	a_line_single: assert property (line_start |=> !line_start)
		else $error("line start longer than one cycle");
	a_pixel_window: assert property (pixel_valid |-> line_active)
		else $error("pixel captured outside vertical window");
	a_odd_held: assert property (line_active ##1 !line_start |-> $stable(field_odd))
		else $error("field parity changed inside the field");

	c_field: cover property (field_start);
	c_active: cover property (line_start && line_active);
	c_pixel: cover property (pixel_valid && field_odd);
endmodule // video_capture_monitor

bind video_input_capture video_capture_monitor #(.LINE_W(LINE_W)) video_capture_monitor_i (
	.clk_sys               (clk_sys),
	.nrst                  (nrst),
	.primary_pixel_clock   (primary_pixel_clock),
	.display_ref_clock_one (display_ref_clock_one),
	.capture_ready         (capture_ready),
	.field_start           (field_start),
	.line_start            (line_start),
	.field_odd             (field_odd),
	.line_active           (line_active),
	.line_number           (line_number),
	.pixel_valid           (pixel_valid)
);

// file: verif/video_source_model.sv
// Purpose: External video source driving both pixel ports
// Assumes: Pixel clocks free-run at 160 ns; secondary lags primary by 40 ns
// Notes:   Pins change on the edge opposite the sampling edge
`timescale 1ns/100ps

module video_source_model (
	// Primary port pins
	output logic       primary_pixel_clock,
	output logic       primary_clock_qualifier,
	output logic       primary_vertical_sync,
	output logic       primary_horizontal_sync,
	output logic [7:0] primary_red_bus,
	output logic [7:0] primary_green_bus,
	output logic [7:0] primary_blue_bus,
	output logic [7:0] primary_luma_bus,
	output logic [7:0] primary_chroma_bus,
	output logic       odd_field_indicator,
	// Secondary port pins
	output logic       secondary_pixel_clock,
	output logic       secondary_clock_qualifier,
	output logic       secondary_vertical_sync,
	output logic       secondary_horizontal_sync,
	output logic [7:0] secondary_red_bus,
	output logic [7:0] secondary_green_bus,
	output logic [7:0] secondary_blue_bus
);
	// Slow pixel clock keeps well inside both mode limits
	initial begin
		{primary_clock_qualifier, primary_vertical_sync, primary_horizontal_sync} = 3'h0;
		{secondary_clock_qualifier, secondary_vertical_sync, secondary_horizontal_sync} = 3'h0;
		{primary_red_bus, primary_green_bus, primary_blue_bus, primary_luma_bus} = 32'h0;
		{primary_chroma_bus, odd_field_indicator} = 9'h000;
		{secondary_red_bus, secondary_green_bus, secondary_blue_bus} = 24'h0;
		primary_pixel_clock = 1'b0;
		forever #80 primary_pixel_clock = ~primary_pixel_clock;
	end
	assign #40 secondary_pixel_clock = primary_pixel_clock;

	// One port edge: qualifier, syncs, odd level and a sample tagged k on both ports
	task automatic send(input logic sec, input logic fall, input logic q, input logic vs,
		input logic hs, input logic [7:0] k, input logic odd);
		if (sec && fall)
			@(posedge secondary_pixel_clock);
		else if (sec)
			@(negedge secondary_pixel_clock);
		else if (fall)
			@(posedge primary_pixel_clock);
		else
			@(negedge primary_pixel_clock);
		{primary_clock_qualifier, secondary_clock_qualifier} <= {q, q};
		{primary_vertical_sync, secondary_vertical_sync} <= {vs, vs};
		{primary_horizontal_sync, secondary_horizontal_sync} <= {hs, hs};
		odd_field_indicator <= odd;
		{secondary_red_bus, secondary_green_bus, secondary_blue_bus} <= {k, 8'h11, 8'h22};
		{primary_red_bus, primary_green_bus, primary_blue_bus} <= {8'h33, k, 8'h44};
		{primary_luma_bus, primary_chroma_bus} <= {k, 8'h55};
	endtask
endmodule // video_source_model

// file: verif/video_input_port_capture_tb_top.sv
// Purpose: Self-checking bench for the video input capture block
// Assumes: 50 MHz system clock; source model on both pixel ports
// Notes:   Each field: sync, lines with stalled junk edges, then checks
`timescale 1ns/100ps

module video_input_port_capture_tb_top;
	logic clk_sys, nrst, clk_en, control_load, display_ref_clock_one, display_ref_clock_two;
	logic input_clock_select, display_clock_select, primary_falling_edge, secondary_falling_edge;
	logic vsync_active_low, hsync_active_low, odd_active_low, interlaced, double_pixel, yuv_mode;
	logic primary_pixel_clock, primary_clock_qualifier, primary_vertical_sync, primary_horizontal_sync;
	logic secondary_pixel_clock, secondary_clock_qualifier, secondary_vertical_sync;
	logic secondary_horizontal_sync, odd_field_indicator;
	logic [7:0] primary_red_bus, primary_green_bus, primary_blue_bus, primary_luma_bus, primary_chroma_bus;
	logic [7:0] secondary_red_bus, secondary_green_bus, secondary_blue_bus;
	logic [10:0] odd_field_vertical_start, even_field_vertical_start, line_number;
	logic [11:0] active_h_start, active_width;
	logic capture_ready, field_start, line_start, field_odd, line_active, pixel_valid, pixel_pair;
	logic [47:0] pixel_data;
	logic [47:0] got[$];
	logic host_serial_clock;
	int n_mismatch, tests_run, n_field, n_line;

	video_input_capture video_input_capture_i (.*);
	video_source_model video_source_model_i (.*);

	// System and display reference clocks
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		display_ref_clock_one = 1'b0;
		forever #80 display_ref_clock_one = ~display_ref_clock_one;
	end
	always @* display_ref_clock_two = ~display_ref_clock_one;

	// Collect captured samples and sync pulses
	always @(negedge clk_sys) begin
		if (pixel_valid === 1'b1)
			got.push_back(pixel_data);
		if (field_start === 1'b1)
			n_field++;
		if (line_start === 1'b1)
			n_line++;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		tests_run++;
		if (seen !== want) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	// Packing of sample k: 1 luma/chroma, 2 pixel pair, 3 secondary rgb, else primary rgb
	function automatic logic [47:0] exp_px(input logic [7:0] k, input logic [1:0] mode);
		case (mode)
			2'h1: exp_px = {24'h0, k, 8'h55, 8'h00};
			2'h2: exp_px = {k, 8'h11, 8'h22, 8'h33, k, 8'h44};
			2'h3: exp_px = {24'h0, k, 8'h11, 8'h22};
			default: exp_px = {24'h0, 8'h33, k, 8'h44};
		endcase
	endfunction

	task automatic do_reset(input logic frz);
		int i;
		nrst = 1'b0;
		host_serial_clock = 1'b1;
		repeat (8) @(negedge clk_sys);
		check({capture_ready, field_odd, line_active, line_number, pixel_valid, pixel_data}, 0);
		nrst = 1'b1;
		host_serial_clock = 1'b0;
		@(negedge clk_sys);
		check(capture_ready, 0);
		// A held-low clock enable must keep start-up frozen however many pixel edges pass
		if (frz) begin
			clk_en = 1'b0;
			repeat (100) @(negedge clk_sys);
			check(capture_ready, 0);
			clk_en = 1'b1;
		end
		for (i = 0; i < 300 && capture_ready !== 1'b1; i++)
			@(negedge clk_sys);
		check(capture_ready, 1);
	endtask

	task automatic load(input logic sec, input logic fall, input logic slow, input logic olow,
		input logic il, input logic yuv);
		@(negedge clk_sys);
		{input_clock_select, primary_falling_edge, secondary_falling_edge} = {sec, fall & ~sec, fall & sec};
		{vsync_active_low, hsync_active_low, odd_active_low} = {slow, slow, olow};
		// Secondary with yuv set selects single-pixel secondary capture
		{interlaced, double_pixel, yuv_mode, control_load} = {il, sec & ~yuv, yuv, 1'b1};
		@(negedge clk_sys);
		control_load = 1'b0;
	endtask

	task automatic run(input logic sec, input logic fall, input logic va, input logic odd,
		input int lines, input int first, input logic eodd, input logic [1:0] mode);
		int l;
		int k;
		// Idle edges bring the syncs to the new inactive level before counting
		repeat (2) video_source_model_i.send(sec, fall, 1'b1, ~va, ~va, 8'h00, odd);
		repeat (12) @(negedge clk_sys);
		got.delete();
		n_field = 0;
		n_line = 0;
		// Sync held over two qualified edges must start one field only
		repeat (2) video_source_model_i.send(sec, fall, 1'b1, va, ~va, 8'h00, odd);
		for (l = 0; l < lines; l++) begin
			video_source_model_i.send(sec, fall, 1'b1, ~va, va, 8'h00, odd);
			for (k = 0; k < 6; k++) begin
				// Stalled edge carries active syncs and junk that must be ignored
				video_source_model_i.send(sec, fall, 1'b0, va, va, 8'hFF, odd);
				video_source_model_i.send(sec, fall, 1'b1, ~va, ~va, k[7:0], odd);
			end
		end
		video_source_model_i.send(sec, fall, 1'b1, ~va, ~va, 8'h00, odd);
		repeat (12) @(negedge clk_sys);
		check(n_field, 1);
		check(n_line, lines);
		check(got.size(), (lines - first + 1) * 4);
		foreach (got[i]) check(got[i], exp_px(8'(i % 4 + 1), mode));
		check(field_odd, eodd);
		check(line_number, lines);
		check(pixel_pair, mode == 2'h2);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the few thousand cycles the fields take
	initial begin
		#500000;
		n_mismatch++;
		end_of_test();
	end

	// Main sequence: progressive, even field, odd polarity, secondary single, then double pixel after a frozen reset
	initial begin
		nrst = 1'b0;
		clk_en = 1'b1;
		{control_load, display_clock_select, input_clock_select, primary_falling_edge} = 4'h0;
		{secondary_falling_edge, vsync_active_low, hsync_active_low, odd_active_low} = 4'h0;
		{interlaced, double_pixel, yuv_mode} = 3'h0;
		odd_field_vertical_start = 11'h002;
		even_field_vertical_start = 11'h005;
		active_h_start = 12'h001;
		active_width = 12'h005;
		n_mismatch = 0;
		tests_run = 0;
		do_reset(1'b0);
		load(0, 0, 0, 0, 0, 0);
		run(0, 0, 1'b1, 1'b0, 3, 2, 1'b1, 2'h0);
		load(0, 1, 1, 0, 1, 1);
		run(0, 1, 1'b0, 1'b0, 6, 5, 1'b0, 2'h1);
		load(0, 0, 0, 1, 1, 0);
		run(0, 0, 1'b1, 1'b0, 3, 2, 1'b1, 2'h0);
		load(1, 0, 0, 0, 0, 1);
		run(1, 0, 1'b1, 1'b0, 3, 2, 1'b1, 2'h3);
		do_reset(1'b1);
		load(1, 1, 0, 0, 0, 0);
		run(1, 1, 1'b1, 1'b0, 3, 2, 1'b1, 2'h2);
		end_of_test();
	end
endmodule // video_input_port_capture_tb_top
